/* rtl/psc_regs.sv */
// Status and configuration register bank of the single-pair transceiver.
// Assumes core condition inputs on clk_sys_in; enable pin and TX enable are async pins.
`timescale 1ns/10ps
`default_nettype none

module psc_regs (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic reset_in,
  // Management register port
  input wire logic [4:0] reg_addr_in,
  input wire logic reg_rd_in,
  input wire logic reg_wr_in,
  input wire logic [15:0] reg_wdata_in,
  output logic [15:0] reg_rdata_out,
  output logic reg_rvalid_out,
  // Core conditions, same clock
  input wire logic pll_locked_in,
  input wire logic local_wake_in,
  input wire logic remote_wake_in,
  input wire logic state_change_done_in,
  input wire logic sleep_request_mode_in,
  input wire logic rx_data_valid_in,
  input wire logic link_fail_in,
  input wire logic link_run_enable_in,
  input wire logic local_rx_ok_in,
  input wire logic remote_rx_ok_in,
  // Supply and temperature monitors
  input wire logic uv_digital_3v3_in,
  input wire logic uv_analog_3v3_in,
  input wire logic uv_core_1v8_in,
  input wire logic uv_io_in,
  input wire logic temp_high_in,
  input wire logic temp_warn_in,
  // Cable diagnosis
  input wire logic cable_short_in,
  input wire logic cable_open_in,
  input wire logic polarity_inverted_in,
  input wire logic interleave_ba_in,
  // Asynchronous pins
  input wire logic enable_pin_in,
  input wire logic mac_tx_enable_in,
  // Reset straps for setup defaults
  input wire logic self_run_strap_in,
  input wire logic regulator_strap_in,
  // Configuration outputs
  output logic self_run_select_out,
  output logic [1:0] clock_source_out,
  output logic core_regulator_select_out
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic en_meta;               // Enable pin first stage
    logic en_sync;               // Enable pin second stage
    logic txen_meta;             // TX enable first stage
    logic txen_sync;             // TX enable second stage
    logic pll_ok;                // Latched-low lock
    logic local_wake_flag;       // Local wake latch
    logic remote_wake_flag;      // Remote wake latch
    logic wake_armed;            // Wake detection enabled
    logic sleep_req_traffic_flag; // Traffic in sleep request
    logic enable_pin_drop_flag;  // Enable went low
    logic hw_reset_seen_flag;    // Reset occurred
    logic [4:0] link_loss_count; // Link failures since read
    logic digital_3v3_low_flag;  // Supply latches
    logic analog_3v3_low_flag;
    logic core_1v8_low_flag;
    logic io_supply_low_flag;
    logic temp_high_flag;        // Overtemperature latch
    logic temp_warn_flag;        // Warning latch
    logic short_flag;            // Cable short latch
    logic open_flag;             // Cable open latch
    logic [7:0] local_rx_bad_count;  // Local receiver faults
    logic [7:0] remote_rx_bad_count; // Remote receiver faults
    logic self_run_select;       // Operation mode
    logic [1:0] clock_source;    // Clock source code
    logic core_regulator_select; // Regulator select
    logic strap_pending;         // Straps not yet captured
    logic [15:0] rdata;          // Read answer
    logic rvalid;                // Read answer valid
  } psc_state_s;

  psc_state_s st_r;   // Registered state
  psc_state_s st_nxt; // Next state

  // Decoded accesses
  logic rd_gs;  // Read of general flags
  logic rd_es;  // Read of external flags
  logic rd_fc;  // Read of fault counters
  logic wr_ss;  // Write of shared setup
  logic [15:0] gs_word; // General flags view
  logic [15:0] es_word; // External flags view
  logic [15:0] fc_word; // Counter view
  logic [15:0] ss_word; // Setup view

  // ----------------------------------------------------------------
  // Address decode and read views
  // ----------------------------------------------------------------
  // Strobes for each register
  always_comb begin
    rd_gs = reg_rd_in && (reg_addr_in == psc_pkg::GENERAL_CONDITION_FLAGS_ADDR);
    rd_es = reg_rd_in && (reg_addr_in == psc_pkg::EXTERNAL_CONDITION_FLAGS_ADDR);
    rd_fc = reg_rd_in && (reg_addr_in == psc_pkg::RECEIVER_FAULT_COUNTERS_ADDR);
    wr_ss = reg_wr_in && (reg_addr_in == psc_pkg::SHARED_SETUP_ADDR);
  end

  // Assemble register words; reserved bits read zero
  always_comb begin
    gs_word = '0;
    gs_word[psc_pkg::GS_PLL_BIT] = st_r.pll_ok;
    gs_word[psc_pkg::GS_LOCAL_WAKE_BIT] = st_r.local_wake_flag;
    gs_word[psc_pkg::GS_REMOTE_WAKE_BIT] = st_r.remote_wake_flag;
    gs_word[psc_pkg::GS_TRAFFIC_BIT] = st_r.sleep_req_traffic_flag;
    gs_word[psc_pkg::GS_EN_DROP_BIT] = st_r.enable_pin_drop_flag;
    gs_word[psc_pkg::GS_HW_RESET_BIT] = st_r.hw_reset_seen_flag;
    gs_word[psc_pkg::GS_LINK_MSB:psc_pkg::GS_LINK_LSB] = st_r.link_loss_count;
    es_word = '0;
    es_word[psc_pkg::ES_DIG_3V3_BIT] = st_r.digital_3v3_low_flag;
    es_word[psc_pkg::ES_ANA_3V3_BIT] = st_r.analog_3v3_low_flag;
    es_word[psc_pkg::ES_CORE_1V8_BIT] = st_r.core_1v8_low_flag;
    es_word[psc_pkg::ES_IO_BIT] = st_r.io_supply_low_flag;
    es_word[psc_pkg::ES_TEMP_HIGH_BIT] = st_r.temp_high_flag;
    es_word[psc_pkg::ES_TEMP_WARN_BIT] = st_r.temp_warn_flag;
    es_word[psc_pkg::ES_SHORT_BIT] = st_r.short_flag;
    es_word[psc_pkg::ES_OPEN_BIT] = st_r.open_flag;
    es_word[psc_pkg::ES_POLARITY_BIT] = polarity_inverted_in;
    es_word[psc_pkg::ES_INTERLEAVE_BIT] = interleave_ba_in;
    fc_word = {st_r.local_rx_bad_count, st_r.remote_rx_bad_count};
    ss_word = '0;
    ss_word[psc_pkg::SS_SELF_RUN_BIT] = st_r.self_run_select;
    ss_word[psc_pkg::SS_CLK_MSB:psc_pkg::SS_CLK_LSB] = st_r.clock_source;
    ss_word[psc_pkg::SS_REG_BIT] = st_r.core_regulator_select;
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    // Pin synchronisers
    st_nxt.en_meta = enable_pin_in;
    st_nxt.en_sync = st_r.en_meta;
    st_nxt.txen_meta = mac_tx_enable_in;
    st_nxt.txen_sync = st_r.txen_meta;

    // Latched-low lock: read reloads live, else only falls
    if (rd_gs) begin
      st_nxt.pll_ok = pll_locked_in;
    end else begin
      st_nxt.pll_ok = st_r.pll_ok & pll_locked_in;
    end

    // Wake flags: set wins over read clear, gated by arming
    st_nxt.local_wake_flag = (st_r.local_wake_flag & ~rd_gs)
                             | (local_wake_in & st_r.wake_armed);
    st_nxt.remote_wake_flag = (st_r.remote_wake_flag & ~rd_gs)
                              | (remote_wake_in & st_r.wake_armed);
    // Clearing a set wake flag disarms until a state change completes
    if (state_change_done_in) begin
      st_nxt.wake_armed = 1'b1;
    end else if (rd_gs && (st_r.local_wake_flag || st_r.remote_wake_flag)) begin
      st_nxt.wake_armed = 1'b0;
    end

    // Traffic seen while in sleep request
    st_nxt.sleep_req_traffic_flag = (st_r.sleep_req_traffic_flag & ~rd_gs)
      | (sleep_request_mode_in & (rx_data_valid_in | st_r.txen_sync));
    // Enable pin low, sampled after synchroniser
    st_nxt.enable_pin_drop_flag = (st_r.enable_pin_drop_flag & ~rd_gs) | ~st_r.en_sync;
    // Reset flag only clears on read; reset itself sets it
    st_nxt.hw_reset_seen_flag = st_r.hw_reset_seen_flag & ~rd_gs;

    // Link loss count, kept regardless of link run enable
    if (rd_gs) begin
      st_nxt.link_loss_count = {{(psc_pkg::LINK_CNT_W - 1){1'b0}}, link_fail_in};
    end else if (link_fail_in && st_r.link_loss_count != psc_pkg::LINK_CNT_MAX) begin
      st_nxt.link_loss_count = st_r.link_loss_count + 5'h01;
    end

    // Supply undervoltage latches
    st_nxt.digital_3v3_low_flag = (st_r.digital_3v3_low_flag & ~rd_es) | uv_digital_3v3_in;
    st_nxt.analog_3v3_low_flag = (st_r.analog_3v3_low_flag & ~rd_es) | uv_analog_3v3_in;
    st_nxt.core_1v8_low_flag = (st_r.core_1v8_low_flag & ~rd_es) | uv_core_1v8_in;
    st_nxt.io_supply_low_flag = (st_r.io_supply_low_flag & ~rd_es) | uv_io_in;
    // Temperature latches
    st_nxt.temp_high_flag = (st_r.temp_high_flag & ~rd_es) | temp_high_in;
    st_nxt.temp_warn_flag = (st_r.temp_warn_flag & ~rd_es) | temp_warn_in;
    // Cable fault latches
    st_nxt.short_flag = (st_r.short_flag & ~rd_es) | cable_short_in;
    st_nxt.open_flag = (st_r.open_flag & ~rd_es) | cable_open_in;

    // Receiver fault counters: clear on read, keep a fresh fault
    if (rd_fc) begin
      st_nxt.local_rx_bad_count = {{(psc_pkg::RX_CNT_W - 1){1'b0}}, ~local_rx_ok_in};
      st_nxt.remote_rx_bad_count = {{(psc_pkg::RX_CNT_W - 1){1'b0}}, ~remote_rx_ok_in};
    end else begin
      if (!local_rx_ok_in && st_r.local_rx_bad_count != psc_pkg::RX_CNT_MAX) begin
        st_nxt.local_rx_bad_count = st_r.local_rx_bad_count + 8'h01;
      end
      if (!remote_rx_ok_in && st_r.remote_rx_bad_count != psc_pkg::RX_CNT_MAX) begin
        st_nxt.remote_rx_bad_count = st_r.remote_rx_bad_count + 8'h01;
      end
    end

    // Setup: strap capture after reset, then software writes
    if (st_r.strap_pending) begin
      st_nxt.self_run_select = self_run_strap_in;
      st_nxt.core_regulator_select = regulator_strap_in;
      st_nxt.strap_pending = 1'b0;
    end
    if (wr_ss) begin
      st_nxt.self_run_select = reg_wdata_in[psc_pkg::SS_SELF_RUN_BIT];
      st_nxt.clock_source = reg_wdata_in[psc_pkg::SS_CLK_MSB:psc_pkg::SS_CLK_LSB];
      st_nxt.core_regulator_select = reg_wdata_in[psc_pkg::SS_REG_BIT];
    end

    // Read answer from the values held before any clear
    st_nxt.rvalid = reg_rd_in;
    if (reg_rd_in) begin
      unique case (reg_addr_in)
        psc_pkg::GENERAL_CONDITION_FLAGS_ADDR: st_nxt.rdata = gs_word;
        psc_pkg::EXTERNAL_CONDITION_FLAGS_ADDR: st_nxt.rdata = es_word;
        psc_pkg::RECEIVER_FAULT_COUNTERS_ADDR: st_nxt.rdata = fc_word;
        psc_pkg::SHARED_SETUP_ADDR: st_nxt.rdata = ss_word;
        default: st_nxt.rdata = '0; // Unmapped reads zero
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Synchronous reset; link run enable clears nothing here
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      st_r <= '0;
      st_r.en_sync <= 1'b1;
      st_r.en_meta <= 1'b1;
      st_r.wake_armed <= 1'b1;
      st_r.hw_reset_seen_flag <= 1'b1;
      st_r.clock_source <= psc_pkg::CLK_SRC_RESET;
      st_r.strap_pending <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs
  assign reg_rdata_out = st_r.rdata;
  assign reg_rvalid_out = st_r.rvalid;
  assign self_run_select_out = st_r.self_run_select;
  assign clock_source_out = st_r.clock_source;
  assign core_regulator_select_out = st_r.core_regulator_select;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);

  property p_lock_low;
    (!pll_locked_in || (!st_r.pll_ok && !rd_gs)) |=> !st_r.pll_ok;
  endproperty
  a_lock_low: assert property (p_lock_low) else $error("lock flag not latched low");

  property p_local_wake;
    (local_wake_in && st_r.wake_armed) |=> st_r.local_wake_flag;
  endproperty
  a_local_wake: assert property (p_local_wake) else $error("local wake not latched");

  property p_disarm;
    (rd_gs && st_r.remote_wake_flag && !state_change_done_in) |=> !st_r.wake_armed;
  endproperty
  a_disarm: assert property (p_disarm) else $error("wake not disarmed after read");

  property p_traffic;
    (sleep_request_mode_in && rx_data_valid_in) |=> st_r.sleep_req_traffic_flag;
  endproperty
  a_traffic: assert property (p_traffic) else $error("traffic flag not latched");

  property p_reset_seen;
    $fell(reset_in) |-> st_r.hw_reset_seen_flag;
  endproperty
  a_reset_seen: assert property (p_reset_seen) else $error("reset flag missing");

  property p_link_count;
    (link_fail_in && !rd_gs && st_r.link_loss_count != psc_pkg::LINK_CNT_MAX)
      |=> st_r.link_loss_count == $past(st_r.link_loss_count) + 5'h01;
  endproperty
  a_link_count: assert property (p_link_count) else $error("link loss count wrong");

  property p_io_low;
    uv_io_in ##1 !rd_es |=> st_r.io_supply_low_flag;
  endproperty
  a_io_low: assert property (p_io_low) else $error("io undervoltage not held");

  property p_local_sat;
    (st_r.local_rx_bad_count == psc_pkg::RX_CNT_MAX && !rd_fc)
      |=> st_r.local_rx_bad_count == psc_pkg::RX_CNT_MAX;
  endproperty
  a_local_sat: assert property (p_local_sat) else $error("local count wrapped");

  property p_remote_inc;
    (!remote_rx_ok_in && !rd_fc && st_r.remote_rx_bad_count != psc_pkg::RX_CNT_MAX)
      |=> st_r.remote_rx_bad_count == $past(st_r.remote_rx_bad_count) + 8'h01;
  endproperty
  a_remote_inc: assert property (p_remote_inc) else $error("remote count not incremented");

  property p_count_clear;
    (rd_fc && local_rx_ok_in && remote_rx_ok_in) |=> (fc_word == 16'h0000);
  endproperty
  a_count_clear: assert property (p_count_clear) else $error("counters not cleared by read");

  property p_regulator;
    wr_ss |=> core_regulator_select_out == $past(reg_wdata_in[psc_pkg::SS_REG_BIT]);
  endproperty
  a_regulator: assert property (p_regulator) else $error("regulator select not written");

  property p_read_latch;
    rd_gs |=> reg_rvalid_out && reg_rdata_out[psc_pkg::GS_LOCAL_WAKE_BIT] == $past(st_r.local_wake_flag);
  endproperty
  a_read_latch: assert property (p_read_latch) else $error("read did not return latch");

  // Link disable must leave count and clock source alone
  property p_link_hold;
    (!link_run_enable_in && !link_fail_in && !rd_gs && !wr_ss)
      |=> $stable(st_r.link_loss_count) && $stable(st_r.clock_source);
  endproperty
  a_link_hold: assert property (p_link_hold) else $error("link disable changed count or clock");

endmodule

`default_nettype wire

/* pkg/psc_pkg.sv */
// Constants for the transceiver status and configuration register bank.
// Assumes a single core clock and a 5-bit management register address.
`default_nettype none

package psc_pkg;

  // ----------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------
  localparam int ADDR_W = 5;                              // Management address width
  localparam logic [4:0] GENERAL_CONDITION_FLAGS_ADDR = 5'h18;  // General status
  localparam logic [4:0] EXTERNAL_CONDITION_FLAGS_ADDR = 5'h19; // External status
  localparam logic [4:0] RECEIVER_FAULT_COUNTERS_ADDR = 5'h1A;  // Receiver fault counters
  localparam logic [4:0] SHARED_SETUP_ADDR = 5'h1B;             // Common setup

  // ----------------------------------------------------------------
  // General condition field positions
  // ----------------------------------------------------------------
  localparam int GS_PLL_BIT = 14;        // Synthesizer lock, latched low
  localparam int GS_LOCAL_WAKE_BIT = 13; // Local wake flag
  localparam int GS_REMOTE_WAKE_BIT = 12; // Remote wake flag
  localparam int GS_TRAFFIC_BIT = 11;    // Sleep request traffic flag
  localparam int GS_EN_DROP_BIT = 10;    // Enable pin dropped
  localparam int GS_HW_RESET_BIT = 9;    // Hardware reset seen
  localparam int GS_LINK_LSB = 3;        // Link loss count low bit
  localparam int GS_LINK_MSB = 7;        // Link loss count high bit
  localparam int LINK_CNT_W = 5;         // Link loss count width
  localparam logic [4:0] LINK_CNT_MAX = 5'h1F; // Link loss count ceiling

  // ----------------------------------------------------------------
  // External condition field positions
  // ----------------------------------------------------------------
  localparam int ES_DIG_3V3_BIT = 15;    // Digital 3.3 V undervoltage
  localparam int ES_ANA_3V3_BIT = 14;    // Analog 3.3 V undervoltage
  localparam int ES_CORE_1V8_BIT = 13;   // Core 1.8 V undervoltage
  localparam int ES_IO_BIT = 11;         // IO supply undervoltage
  localparam int ES_TEMP_HIGH_BIT = 10;  // Overtemperature
  localparam int ES_TEMP_WARN_BIT = 9;   // Temperature warning
  localparam int ES_SHORT_BIT = 8;       // Cable short
  localparam int ES_OPEN_BIT = 7;        // Cable open
  localparam int ES_POLARITY_BIT = 6;    // Polarity inversion, live
  localparam int ES_INTERLEAVE_BIT = 5;  // Symbol interleave order, live

  // ----------------------------------------------------------------
  // Receiver fault counters
  // ----------------------------------------------------------------
  localparam int RX_CNT_W = 8;           // Each counter width
  localparam int FC_LOCAL_LSB = 8;       // Local count low bit
  localparam logic [7:0] RX_CNT_MAX = 8'hFF; // Saturation value

  // ----------------------------------------------------------------
  // Shared setup fields
  // ----------------------------------------------------------------
  localparam int SS_SELF_RUN_BIT = 15;   // Managed or autonomous operation
  localparam int SS_CLK_LSB = 12;        // Clock source low bit
  localparam int SS_CLK_MSB = 13;        // Clock source high bit
  localparam int SS_REG_BIT = 11;        // Core regulator select
  localparam logic [1:0] CLK_SRC_RESET = 2'h0; // Crystal, no clock out

  // Clock source codes
  typedef enum logic [1:0] {
    PSC_CLK_XTAL = 2'b00,     // Crystal, no clock out
    PSC_CLK_XTAL_OUT = 2'b01, // Crystal, 25 MHz out
    PSC_CLK_EXT_IN = 2'b10,   // External 25 MHz in
    PSC_CLK_REF50 = 2'b11     // 50 MHz reference, reduced interface
  } psc_clk_src_e;

endpackage

`default_nettype wire

/* bench/psc_host_model.sv */
// Management host model that drives the register port of the bank.
// Assumes the bench calls its tasks; strobes change only at falling edges.
`timescale 1ns/10ps
`default_nettype none

module psc_host_model (
  // Clock
  input wire logic clk_in,
  // Read answer
  input wire logic [15:0] rdata_in,
  input wire logic rvalid_in,
  // Request lines
  output logic [4:0] addr_out,
  output logic rd_out,
  output logic wr_out,
  output logic [15:0] wdata_out
);
  // ----------------------------------------------------------------
  // Idle request lines from time zero
  // ----------------------------------------------------------------
  initial begin
    addr_out = 5'h00;
    rd_out = 1'h0;
    wr_out = 1'h0;
    wdata_out = 16'h0000;
  end

  // One write strobe of one cycle
  task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
    @(negedge clk_in);
    addr_out = a;
    wdata_out = d;
    wr_out = 1'h1;
    @(negedge clk_in);
    wr_out = 1'h0;
  endtask

  // One read strobe; answer taken only while valid, else unknown
  task automatic rd_reg(input logic [4:0] a, output logic [15:0] d);
    int n;
    @(negedge clk_in);
    addr_out = a;
    rd_out = 1'h1;
    @(negedge clk_in);
    rd_out = 1'h0;
    for (n = 0; n < 3 && rvalid_in !== 1'h1; n++) begin
      @(negedge clk_in);
    end
    d = (rvalid_in === 1'h1) ? rdata_in : 16'hXXXX;
  endtask

  // Traffic flag is not trusted while the IO supply flag is up
  function automatic logic [15:0] host_view(input logic [15:0] g, input logic [15:0] e);
    host_view = e[11] ? (g & 16'hF7FF) : g;
  endfunction
endmodule

`default_nettype wire

/* bench/tb_phy_status_config_regs.sv */
// Self-checking bench for the status and configuration register bank.
// Assumes psc_pkg is compiled first; the host model drives the register port.
`timescale 1ns/10ps
`default_nettype none

module tb_phy_status_config_regs;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam logic [4:0] GA = psc_pkg::GENERAL_CONDITION_FLAGS_ADDR; // General flags
  localparam logic [4:0] EA = psc_pkg::EXTERNAL_CONDITION_FLAGS_ADDR; // External flags
  localparam logic [4:0] CA = psc_pkg::RECEIVER_FAULT_COUNTERS_ADDR; // Fault counters
  localparam logic [4:0] SA = psc_pkg::SHARED_SETUP_ADDR; // Setup
  logic clk_sys_in = 1'h0, reset_in = 1'h1; // Clock and reset
  logic [11:0] ev = 12'h000; // Event pulses, one per latched source
  logic pll = 1'h1, sc_done = 1'h0, sleep = 1'h0, rxdv = 1'h0, txen = 1'h0; // Core conditions
  logic lre = 1'h1, lok = 1'h1, rok = 1'h1, pol = 1'h0, ilv = 1'h0; // Link and cable
  logic [4:0] addr; // Host address
  logic rd, wr, rvalid, self_run, reg_sel; // Strobes and setup outputs
  logic [1:0] clk_src; // Clock source output
  logic [15:0] wdata, rdata, got, got2; // Data words
  int fail_count = 0, num_checks = 0, cycles = 0, i; // Counters
  // Table rows: address read after pulsing ev[row], expected word
  logic [4:0] row_addr [12] = '{GA, GA, EA, EA, EA, EA, EA, EA, EA, EA, GA, GA};
  logic [15:0] row_exp [12] = '{16'h6000, 16'h5000, 16'h8000, 16'h4000, 16'h2000, 16'h0800,
    16'h0400, 16'h0200, 16'h0100, 16'h0080, 16'h4008, 16'h4400};

  // Clock, 8 ns period
  always #4 clk_sys_in = ~clk_sys_in;

  // ----------------------------------------------------------------
  // Design and host
  // ----------------------------------------------------------------
  psc_regs dut (.clk_sys_in(clk_sys_in), .reset_in(reset_in), .reg_addr_in(addr), .reg_rd_in(rd),
    .reg_wr_in(wr), .reg_wdata_in(wdata), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
    .pll_locked_in(pll), .local_wake_in(ev[0]), .remote_wake_in(ev[1]), .state_change_done_in(sc_done),
    .sleep_request_mode_in(sleep), .rx_data_valid_in(rxdv), .link_fail_in(ev[10]), .link_run_enable_in(lre),
    .local_rx_ok_in(lok), .remote_rx_ok_in(rok), .uv_digital_3v3_in(ev[2]), .uv_analog_3v3_in(ev[3]),
    .uv_core_1v8_in(ev[4]), .uv_io_in(ev[5]), .temp_high_in(ev[6]), .temp_warn_in(ev[7]),
    .cable_short_in(ev[8]), .cable_open_in(ev[9]), .polarity_inverted_in(pol), .interleave_ba_in(ilv),
    .enable_pin_in(~ev[11]), .mac_tx_enable_in(txen), .self_run_strap_in(1'h1), .regulator_strap_in(1'h1),
    .self_run_select_out(self_run), .clock_source_out(clk_src), .core_regulator_select_out(reg_sel));
  psc_host_model host (.clk_in(clk_sys_in), .rdata_in(rdata), .rvalid_in(rvalid), .addr_out(addr),
    .rd_out(rd), .wr_out(wr), .wdata_out(wdata));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Word compare
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Read and compare
  task automatic rchk(input logic [4:0] a, input logic [15:0] exp);
    logic [15:0] d;
    host.rd_reg(a, d);
    chk($sformatf("register %h", a), exp, d);
  endtask
  // Setup outputs as {self run, clock source, regulator}
  task automatic ochk(input logic [15:0] exp);
    chk("setup outputs", exp, {12'h000, self_run, clk_src, reg_sel});
  endtask
  // Falling edges to wait
  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys_in);
  endtask
  // Reset for 20 cycles
  task automatic do_reset;
    @(negedge clk_sys_in);
    reset_in = 1'h1;
    tick(20);
    reset_in = 1'h0;
    tick(2);
  endtask
  // Local wake pulse then general read
  task automatic wake_chk(input logic [15:0] exp);
    ev[0] = 1'h1;
    tick(1);
    ev[0] = 1'h0;
    tick(2);
    rchk(GA, exp);
  endtask
  // Both receivers bad; one for 2 cycles, other for 300
  task automatic faults(input logic loc_long, input logic [15:0] exp);
    lok = 1'h0;
    rok = 1'h0;
    tick(2);
    if (loc_long) rok = 1'h1;
    else lok = 1'h1;
    tick(298);
    lok = 1'h1;
    rok = 1'h1;
    tick(1);
    rchk(CA, exp);
  endtask
  // Verdict and end of run
  task automatic report_and_stop;
    if (fail_count == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Hang guard
  always @(posedge clk_sys_in) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      fail_count++;
      report_and_stop();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    do_reset();
    rchk(GA, 16'h0200);
    rchk(GA, 16'h4000);
    rchk(SA, 16'h8800);
    ochk(16'h0009);
    rchk(CA, 16'h0000);
    rchk(5'h00, 16'h0000);
    // Each latched source: set once, then cleared by the read
    for (i = 0; i < 12; i++) begin
      sc_done = 1'h1;
      tick(1);
      sc_done = 1'h0;
      ev[i] = 1'h1;
      tick(1);
      ev[i] = 1'h0;
      tick(4);
      rchk(row_addr[i], row_exp[i]);
      rchk(row_addr[i], (row_addr[i] == GA) ? 16'h4000 : 16'h0000);
    end
    // Wake disarmed by read until a state change
    wake_chk(16'h6000);
    wake_chk(16'h4000);
    sc_done = 1'h1;
    tick(1);
    sc_done = 1'h0;
    wake_chk(16'h6000);
    // Lock lost for one cycle
    pll = 1'h0;
    tick(1);
    pll = 1'h1;
    tick(2);
    rchk(GA, 16'h0000);
    rchk(GA, 16'h4000);
    // Traffic in sleep request, by line data then by TX enable, then outside it
    sleep = 1'h1;
    rxdv = 1'h1;
    tick(1);
    rxdv = 1'h0;
    tick(2);
    rchk(GA, 16'h4800);
    txen = 1'h1;
    tick(1);
    txen = 1'h0;
    tick(4);
    rchk(GA, 16'h4800);
    sleep = 1'h0;
    rxdv = 1'h1;
    txen = 1'h1;
    tick(1);
    rxdv = 1'h0;
    txen = 1'h0;
    tick(4);
    rchk(GA, 16'h4000);
    // IO undervoltage during sleep request
    sleep = 1'h1;
    ev[5] = 1'h1;
    rxdv = 1'h1;
    tick(1);
    ev[5] = 1'h0;
    rxdv = 1'h0;
    sleep = 1'h0;
    tick(2);
    host.rd_reg(GA, got);
    host.rd_reg(EA, got2);
    chk("raw general", 16'h4800, got);
    chk("io flag", 16'h0800, got2);
    chk("host view", 16'h4000, host.host_view(got, got2));
    // Live cable bits
    pol = 1'h1;
    ilv = 1'h1;
    tick(2);
    rchk(EA, 16'h0060);
    pol = 1'h0;
    tick(2);
    rchk(EA, 16'h0020);
    ilv = 1'h0;
    tick(2);
    rchk(EA, 16'h0000);
    // Fault counters: exact count, saturation, clear on read
    faults(1'h1, 16'hFF02);
    rchk(CA, 16'h0000);
    faults(1'h0, 16'h02FF);
    rchk(CA, 16'h0000);
    // Every clock source code, reserved bits read back 0
    for (i = 0; i < 4; i++) begin
      host.wr_reg(SA, {i[0], 1'h1, i[1:0], i[1], 11'h7FF});
      tick(1);
      rchk(SA, {i[0], 1'h0, i[1:0], i[1], 11'h000});
      ochk({12'h000, i[0], i[1:0], i[1]});
    end
    // Write elsewhere ignored
    host.wr_reg(EA, 16'hFFFF);
    tick(1);
    rchk(SA, 16'hB800);
    // Link disable keeps count and clock source
    ev[10] = 1'h1;
    tick(2);
    ev[10] = 1'h0;
    lre = 1'h0;
    tick(2);
    lre = 1'h1;
    rchk(GA, 16'h4010);
    ochk(16'h000F);
    // Second reset in mid-run
    do_reset();
    ochk(16'h0009);
    rchk(GA, 16'h0200);
    report_and_stop();
  end
endmodule

`default_nettype wire
